// ===== include/gls_defines.vh
// Constants for the guard lock supervisor
`ifndef GLS_DEFINES_VH
`define GLS_DEFINES_VH

`define GLS_CLK_MHZ 250
`define GLS_TICK_MS 1
// One millisecond of the 250 MHz clock
`define GLS_TICK_CYCLES 18'h3d090

`define GLS_ADDR_CTRL 8'h00
`define GLS_ADDR_UNLOCK_SEL 8'h04
`define GLS_ADDR_FBK_SEL 8'h08
`define GLS_ADDR_STATUS 8'h0c
`define GLS_ADDR_MASK 8'h10
`define GLS_ADDR_STATE 8'h14

`define GLS_CTRL_NO_GATE 0
`define GLS_CTRL_MANDATORY 1
`define GLS_CTRL_SPRING 2
`define GLS_CTRL_ERR_EN 3
`define GLS_CTRL_MONITORED 4
`define GLS_CTRL_RST 5'h04
`define GLS_UNLOCK_SEL_RST 5'h00
`define GLS_FBK_SEL_RST 5'h09

`define GLS_EV_FAULT 0
`define GLS_EV_SAFE_RISE 1
`define GLS_EV_SAFE_FALL 2

`define GLS_UD_SEG1_LAST 5'h0a
`define GLS_UD_STEP1_MS 15'h0064
`define GLS_UD_SEG2_FIRST 5'h0b
`define GLS_UD_SEG2_LAST 5'h1c
`define GLS_UD_BASE2_MS 15'h05dc
`define GLS_UD_STEP2_MS 15'h01f4
`define GLS_UD_SEG3_FIRST 5'h1d
`define GLS_UD_BASE3_MS 15'h3a98
`define GLS_UD_STEP3_MS 15'h1388

`define GLS_FB_SEG1_LAST 5'h09
`define GLS_FB_BASE1_MS 15'h000a
`define GLS_FB_STEP1_MS 15'h000a
`define GLS_FB_SEG2_FIRST 5'h0a
`define GLS_FB_SEG2_LAST 5'h1b
`define GLS_FB_BASE2_MS 15'h0096
`define GLS_FB_STEP2_MS 15'h0032
`define GLS_FB_SEG3_FIRST 5'h1c
`define GLS_FB_BASE3_MS 15'h05dc
`define GLS_FB_STEP3_MS 15'h01f4

`endif

// ===== tb/gls_guard_lock_sva.sv
// Port-level checks for the guard lock supervisor
`timescale 1ns/1ps
module gls_guard_lock_sva (
  input wire clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire unlock_cmd,
  input wire lock_fbk,
  input wire safe_out,
  input wire lock_out,
  input wire magnet_activation_trace,
  input wire fault_flag_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  unlock_safe_a: assert property ($rose(unlock_cmd) ##1 unlock_cmd [*2] |=> !safe_out)
    else $error("safe output kept during unlock request");
  safe_trace_a: assert property (safe_out |-> !magnet_activation_trace)
    else $error("safe output while release commanded");
  fault_safe_a: assert property (fault_flag_out |-> !safe_out)
    else $error("safe output during fault");
  fbk_loss_a: assert property (safe_out && $changed(lock_fbk) |-> ##[1:3] !safe_out)
    else $error("feedback change ignored while safe");
  drive_trace_a: assert property ($changed(magnet_activation_trace) |-> $changed(lock_out))
    else $error("magnet drive does not follow release");
  release_safe_a: assert property ($rose(magnet_activation_trace) |-> !safe_out && !$past(safe_out))
    else $error("release without prior safe drop");
  relock_cmd_a: assert property ($fell(magnet_activation_trace) && $past(unlock_cmd, 2) |-> ##[0:1] fault_flag_out)
    else $error("relock while unlock still requested");
  cover property ($rose(safe_out));
  cover property ($rose(fault_flag_out));
  cover property ($rose(magnet_activation_trace));
endmodule

bind gls_guard_lock gls_guard_lock_sva i_sva (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .unlock_cmd,
  .lock_fbk, .safe_out, .lock_out, .magnet_activation_trace, .fault_flag_out);

// ===== tb/gls_guard_lock_tb.sv
// Self-checking bench for the guard lock supervisor
`timescale 1ns/1ps
`include "gls_defines.vh"
module gls_guard_lock_tb;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, act = 8'h14;
  logic [31:0] wd = 32'h0, rd;
  logic ack, fbk, safe, lko, trc, flt, irq;
  logic unl = 1'b0, gate = 1'b1, rcmd = 1'b0, stuck = 1'b0, kick = 1'b0;
  logic [31:0] expq[$];
  int err_total = 0;
  int samples_checked = 0;
  int n;
  always #2 clk = ~clk;
  gls_guard_lock #(.TICK_CYCLES(18'h0000a)) i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .unlock_cmd(unl), .lock_fbk(fbk), .gate_closed(gate), .reset_cmd(rcmd), .safe_out(safe), .lock_out(lko),
    .magnet_activation_trace(trc), .fault_flag_out(flt), .irq(irq));
  gls_lock_model i_lock (.clk(clk), .lock_out(lko), .stuck(stuck), .kick(kick), .act_cycles(act), .lock_fbk(fbk));
  task automatic final_report;
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reads pass the expected data, which the watcher compares at ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    if (!w) expq.push_back(d);
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      final_report;
    end
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) chk(rd, expq.pop_front());
  end
  function automatic logic pick(input int w);
    pick = (w == 0) ? safe : (w == 1) ? trc : flt;
  endfunction
  task automatic wt(input int w, input logic v, input int lim);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (pick(w) !== v) begin
      err_total++;
      final_report;
    end
  endtask
  initial begin
    n = $urandom(32'h62d6900e);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, `GLS_ADDR_CTRL, 32'h04);
    bus(0, `GLS_ADDR_UNLOCK_SEL, 32'h00);
    bus(0, `GLS_ADDR_FBK_SEL, 32'h09);
    bus(0, `GLS_ADDR_MASK, 32'h00);
    wt(0, 1, 2000);
    chk(lko, 0);
    bus(1, `GLS_ADDR_CTRL, 32'h0d);
    bus(1, `GLS_ADDR_FBK_SEL, 32'h00);
    bus(1, `GLS_ADDR_UNLOCK_SEL, 32'h01);
    bus(1, `GLS_ADDR_MASK, 32'h07);
    bus(1, 8'h18, 32'hff);
    bus(0, 8'h18, 32'h00);
    chk(irq, 1);
    bus(0, `GLS_ADDR_STATUS, 32'h02);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    // Door contact left open: without a door it must be ignored
    act <= 8'h0a + 8'($urandom % 60);
    gate <= 1'b0;
    unl <= 1'b1;
    repeat (4) @(posedge clk);
    chk(safe, 0);
    wt(1, 1, 1100);
    chk(n >= 995 && n <= 1015, 1);
    chk(lko, 1);
    repeat (150) @(posedge clk);
    chk(flt, 0);
    unl <= 1'b0;
    wt(0, 1, 300);
    // Magnet never pulls in: late feedback
    stuck <= 1'b1;
    unl <= 1'b1;
    wt(1, 1, 1100);
    wt(2, 1, 200);
    chk(n >= 100 && n <= 125, 1);
    chk(safe, 0);
    unl <= 1'b0;
    stuck <= 1'b0;
    bus(0, `GLS_ADDR_STATUS, 32'h07);
    rcmd <= 1'b1;
    repeat (6) @(posedge clk);
    rcmd <= 1'b0;
    wt(0, 1, 300);
    // Door mode with mandatory opening and monitored reset
    gate <= 1'b1;
    bus(1, `GLS_ADDR_CTRL, 32'h1e);
    bus(1, `GLS_ADDR_UNLOCK_SEL, 32'h00);
    unl <= 1'b1;
    wt(1, 1, 100);
    repeat (100) @(posedge clk);
    unl <= 1'b0;
    wt(2, 1, 400);
    chk(safe, 0);
    rcmd <= 1'b1;
    repeat (6) @(posedge clk);
    chk(flt, 1);
    rcmd <= 1'b0;
    wt(2, 0, 20);
    wt(0, 1, 300);
    unl <= 1'b1;
    wt(1, 1, 100);
    repeat (100) @(posedge clk);
    gate <= 1'b0;
    repeat (20) @(posedge clk);
    unl <= 1'b0;
    repeat (50) @(posedge clk);
    chk(trc, 1);
    gate <= 1'b1;
    wt(0, 1, 400);
    chk(flt, 0);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    repeat (6) @(posedge clk);
    chk(safe, 0);
    bus(1, `GLS_ADDR_CTRL, 32'h09);
    repeat (4) @(posedge clk);
    chk(lko, 1);
    final_report;
  end
endmodule

// ===== tb/gls_lock_model.sv
// Behavioural guard lock whose magnet contact follows the drive after a delay
`timescale 1ns/1ps
module gls_lock_model (
  input wire clk,
  input wire lock_out,
  input wire stuck,
  input wire kick,
  input wire [7:0] act_cycles,
  output logic lock_fbk
);
  logic [7:0] cnt = 8'h00;
  initial lock_fbk = 1'b0;
  // Kick makes the contact bounce once; stuck freezes the magnet
  always @(posedge clk) begin
    if (kick) begin
      lock_fbk <= ~lock_fbk;
    end else if (stuck || lock_fbk == lock_out) begin
      cnt <= 8'h00;
    end else if (cnt >= act_cycles) begin
      lock_fbk <= lock_out;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ===== verilog/gls_guard_lock.v
// Guard lock supervisor with Wishbone register access
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "gls_defines.vh"

// Operation
// RULE_01: Safe output high only with door closed and lock confirmed by feedback.
// RULE_02: Unlock request drops the safe output at once and releases via magnet drive.
// RULE_03: Errors such as door open while locked or late feedback force safe low.
// RULE_04: Magnet drive releases only after the configured unlock delay.
// RULE_05: Error if feedback does not follow the magnet drive within the feedback time.
// RULE_06: Command source holds the request high to unlock, low to lock.
// RULE_07: With a door, re-lock after request release only once the door is closed.
// RULE_08: After re-lock, safe returns only with feedback locked and door closed.
// RULE_09: Mandatory opening: error at cycle end if the door was never seen open.
// RULE_10: Mandatory opening: cycle completes only after door opened then closed.
// RULE_11: No-door option ignores the door input and supervises feedback only.
// RULE_12: Manual reset on a 0 to 1 edge; monitored needs 0 to 1 then back to 0.
// RULE_13: Unlock delay 0-1 s by 100 ms, 1.5-10 s by 0.5 s, 15-25 s by 5 s.
// RULE_14: Feedback time 10 ms steps low, 50 ms to 1 s, 0.5 s steps to 3 s.
// RULE_15: Spring option: de-energised magnet is locked; energise only to release.
// RULE_16: Enabled fault output goes to 1 on a lock malfunction.
// RULE_17: Enabled fault output stays low while no error is present.
// RULE_18: Without spring option, energise the magnet to lock, de-energise to release.
// RULE_19: Times are counted in cycles; feedback timer restarts at each drive change.
module gls_guard_lock #(
  parameter [17:0] TICK_CYCLES = `GLS_TICK_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire unlock_cmd,
  input wire lock_fbk,
  input wire gate_closed,
  input wire reset_cmd,
  output wire safe_out,
  output wire lock_out,
  output wire magnet_activation_trace,
  output wire fault_flag_out,
  output wire irq
);

  localparam [2:0] ST_LOCKED = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_UNLOCKED = 3'h2;
  localparam [2:0] ST_RELOCK = 3'h3;
  localparam [2:0] ST_FAULT = 3'h4;

  localparam [17:0] TICK_LAST = TICK_CYCLES - 18'h00001;
  localparam [14:0] MS_MAX = 15'h7fff;

  reg [3:0] meta_reg;
  reg [3:0] sync_reg;
  reg reset_prev_reg;
  reg armed_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg seen_reg;
  reg seen_next;
  reg err;
  reg [17:0] pre_cnt_reg;
  reg [14:0] ms_cnt_reg;
  reg safe_reg;
  reg safe_next;
  reg act_reg;
  reg lock_out_reg;
  reg fault_reg;
  reg [4:0] ctrl_reg;
  reg [4:0] unlock_sel_reg;
  reg [4:0] fbk_sel_reg;
  reg [2:0] status_reg;
  reg [2:0] mask_reg;
  reg ack_reg;
  reg [31:0] dat_o_reg;
  reg [31:0] rd_data;

  wire cmd_s;
  wire fbk_s;
  wire gate_s;
  wire reset_s;
  wire use_gate;
  wire mandatory;
  wire spring;
  wire fb_locked;
  wire gate_ok;
  wire tick;
  wire reset_rise;
  wire reset_fall;
  wire reset_accept;
  wire act_next;
  wire [14:0] unlock_ms;
  wire [14:0] fbk_ms;
  wire fbk_late;
  wire [2:0] events;
  wire wb_req;
  wire wb_wr;
  wire status_rd;

  // Unlock delay code to milliseconds
  function [14:0] unlock_code_ms;
    input [4:0] c;
    begin
      if (c <= `GLS_UD_SEG1_LAST) begin
        unlock_code_ms = {10'h000, c} * `GLS_UD_STEP1_MS;
      end else if (c <= `GLS_UD_SEG2_LAST) begin
        unlock_code_ms = `GLS_UD_BASE2_MS + {10'h000, c - `GLS_UD_SEG2_FIRST} * `GLS_UD_STEP2_MS;
      end else begin
        unlock_code_ms = `GLS_UD_BASE3_MS + {10'h000, c - `GLS_UD_SEG3_FIRST} * `GLS_UD_STEP3_MS;
      end
    end
  endfunction

  // Feedback time code to milliseconds
  function [14:0] fbk_code_ms;
    input [4:0] c;
    begin
      if (c <= `GLS_FB_SEG1_LAST) begin
        fbk_code_ms = `GLS_FB_BASE1_MS + {10'h000, c} * `GLS_FB_STEP1_MS;
      end else if (c <= `GLS_FB_SEG2_LAST) begin
        fbk_code_ms = `GLS_FB_BASE2_MS + {10'h000, c - `GLS_FB_SEG2_FIRST} * `GLS_FB_STEP2_MS;
      end else begin
        fbk_code_ms = `GLS_FB_BASE3_MS + {10'h000, c - `GLS_FB_SEG3_FIRST} * `GLS_FB_STEP3_MS;
      end
    end
  endfunction

  // Two-stage synchronisers for the field inputs
  // They start at 0, so the door reads open for two edges after reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end else begin
      meta_reg <= {reset_cmd, gate_closed, lock_fbk, unlock_cmd};
      sync_reg <= meta_reg;
    end
  end

  assign cmd_s = sync_reg[0];
  assign fbk_s = sync_reg[1];
  assign gate_s = sync_reg[2];
  assign reset_s = sync_reg[3];

  assign use_gate = ~ctrl_reg[`GLS_CTRL_NO_GATE];
  assign mandatory = ctrl_reg[`GLS_CTRL_MANDATORY] & use_gate;
  assign spring = ctrl_reg[`GLS_CTRL_SPRING];

  // Contact shows magnet energised; locked polarity follows the spring option
  assign fb_locked = fbk_s ^ spring; // see RULE_15 RULE_18
  assign gate_ok = ~use_gate | gate_s; // see RULE_11

  assign unlock_ms = unlock_code_ms(unlock_sel_reg); // see RULE_13
  assign fbk_ms = fbk_code_ms(fbk_sel_reg); // see RULE_14
  assign fbk_late = ms_cnt_reg > fbk_ms;

  // Reset input: manual edge or monitored pulse
  assign reset_rise = reset_s & ~reset_prev_reg;
  assign reset_fall = ~reset_s & reset_prev_reg;
  assign reset_accept = ctrl_reg[`GLS_CTRL_MONITORED] ? (reset_fall & armed_reg) : reset_rise; // see RULE_12

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_prev_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      reset_prev_reg <= reset_s;
      if (reset_rise) begin
        armed_reg <= 1'b1;
      end else if (reset_fall) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // Millisecond timebase; restarts on every state change
  // The count saturates, so a long stay in one state never wraps into a false timeout
  assign tick = pre_cnt_reg == TICK_LAST;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg <= 18'h00000;
      ms_cnt_reg <= 15'h0000;
    end else if (state_next != state_reg) begin
      pre_cnt_reg <= 18'h00000; // see RULE_19
      ms_cnt_reg <= 15'h0000;
    end else if (tick) begin
      pre_cnt_reg <= 18'h00000;
      if (ms_cnt_reg != MS_MAX) begin
        ms_cnt_reg <= ms_cnt_reg + 15'h0001;
      end
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 18'h00001;
    end
  end

  // Supervision state machine
  always @* begin
    state_next = state_reg;
    seen_next = seen_reg;
    err = 1'b0;
    case (state_reg)
      ST_LOCKED: begin
        if (cmd_s) begin
          state_next = ST_DELAY; // see RULE_02
          seen_next = 1'b0;
        end else if (!fb_locked || !gate_ok) begin
          err = 1'b1; // see RULE_03
        end
      end
      ST_DELAY: begin
        // The lock is still engaged while the release delay runs
        if (!fb_locked || !gate_ok) begin
          err = 1'b1; // see RULE_03
        end else if (!cmd_s) begin
          state_next = ST_LOCKED;
        end else if (ms_cnt_reg >= unlock_ms) begin
          state_next = ST_UNLOCKED; // see RULE_04
        end
      end
      ST_UNLOCKED: begin
        if (use_gate && !gate_s) begin
          seen_next = 1'b1; // see RULE_10
        end
        if (fb_locked && fbk_late) begin
          err = 1'b1; // see RULE_05
        end else if (!cmd_s && gate_ok) begin
          state_next = ST_RELOCK; // see RULE_07
        end
      end
      ST_RELOCK: begin
        if (fb_locked) begin
          if (mandatory && !seen_reg) begin
            err = 1'b1; // see RULE_09
          end else if (gate_ok) begin
            // Safe is offered again only with gate_ok: the door reading closed, or the door ignored in no-door mode
            state_next = ST_LOCKED; // see RULE_08 RULE_10
          end
        end else if (fbk_late) begin
          err = 1'b1; // see RULE_05
        end
      end
      ST_FAULT: begin
        if (reset_accept) begin
          // An accepted reset closes the cycle, so the opening check is not repeated
          state_next = ST_RELOCK; // see RULE_12
          seen_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_FAULT;
      end
    endcase
    if (err) begin
      state_next = ST_FAULT; // see RULE_03
    end
  end

  always @* begin
    safe_next = (state_next == ST_LOCKED) & fb_locked & gate_ok & ~cmd_s & ~err; // see RULE_01 RULE_08
  end

  // Release is commanded only while the state machine is in the unlocked state
  assign act_next = state_next == ST_UNLOCKED;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Power-up re-checks the lock instead of trusting it
      state_reg <= ST_RELOCK;
      seen_reg <= 1'b0;
      safe_reg <= 1'b0;
      act_reg <= 1'b0;
      lock_out_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      seen_reg <= seen_next;
      safe_reg <= safe_next;
      act_reg <= act_next;
      lock_out_reg <= ~(act_next ^ spring); // see RULE_15 RULE_18
      // An error in the reset cycle keeps the fault latched
      if (err) begin
        fault_reg <= 1'b1; // see RULE_16
      end else if (reset_accept) begin
        fault_reg <= 1'b0; // see RULE_17
      end
    end
  end

  assign safe_out = safe_reg;
  assign lock_out = lock_out_reg;
  assign magnet_activation_trace = act_reg;
  assign fault_flag_out = fault_reg & ctrl_reg[`GLS_CTRL_ERR_EN]; // see RULE_16 RULE_17

  // Events and interrupt
  assign events[`GLS_EV_FAULT] = err;
  assign events[`GLS_EV_SAFE_RISE] = safe_next & ~safe_reg;
  assign events[`GLS_EV_SAFE_FALL] = ~safe_next & safe_reg;
  assign irq = |(status_reg & mask_reg);

  // Wishbone classic slave, one wait state
  // Writes land on the edge that raises ack; ack always follows a request by one cycle
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  assign status_rd = wb_req & ~wb_we_i & (wb_adr_i == `GLS_ADDR_STATUS);

  always @* begin
    rd_data = 32'h00000000;
    case (wb_adr_i)
      `GLS_ADDR_CTRL: begin
        rd_data[4:0] = ctrl_reg;
      end
      `GLS_ADDR_UNLOCK_SEL: begin
        rd_data[4:0] = unlock_sel_reg;
      end
      `GLS_ADDR_FBK_SEL: begin
        rd_data[4:0] = fbk_sel_reg;
      end
      `GLS_ADDR_STATUS: begin
        rd_data[2:0] = status_reg;
      end
      `GLS_ADDR_MASK: begin
        rd_data[2:0] = mask_reg;
      end
      `GLS_ADDR_STATE: begin
        rd_data[6:0] = {seen_reg, fault_reg, lock_out_reg, safe_reg, state_reg};
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      dat_o_reg <= 32'h00000000;
      ctrl_reg <= `GLS_CTRL_RST;
      unlock_sel_reg <= `GLS_UNLOCK_SEL_RST;
      fbk_sel_reg <= `GLS_FBK_SEL_RST;
      mask_reg <= 3'h0;
      status_reg <= 3'h0;
    end else begin
      ack_reg <= wb_req;
      if (wb_req && !wb_we_i) begin
        dat_o_reg <= rd_data;
      end
      if (wb_wr && wb_adr_i == `GLS_ADDR_CTRL) begin
        ctrl_reg <= wb_dat_i[4:0];
      end
      if (wb_wr && wb_adr_i == `GLS_ADDR_UNLOCK_SEL) begin
        unlock_sel_reg <= wb_dat_i[4:0];
      end
      if (wb_wr && wb_adr_i == `GLS_ADDR_FBK_SEL) begin
        fbk_sel_reg <= wb_dat_i[4:0];
      end
      if (wb_wr && wb_adr_i == `GLS_ADDR_MASK) begin
        mask_reg <= wb_dat_i[2:0];
      end
      // A new event in the clearing cycle survives the read
      status_reg <= (status_reg & {3{~status_rd}}) | events;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_o_reg;

endmodule
